// ### design/touch_adc_params.svh
// constants of the converter result status register
// assumes inclusion by every file of this block, before any use
`ifndef TOUCH_ADC_PARAMS_SVH
`define TOUCH_ADC_PARAMS_SVH

// register shape
`define STATUS_WIDTH 16
`define STATUS_RESET 16'h0000
`define CHANNEL_COUNT 9

// flag positions inside the status word
`define BIT_X_RESULT 10
`define BIT_Y_RESULT 9
`define BIT_P1_RESULT 8
`define BIT_P2_RESULT 7
`define BIT_BATTERY_RESULT 6
`define BIT_RESERVED_HIGH 5
`define BIT_AUX_A_RESULT 4
`define BIT_AUX_B_RESULT 3
`define BIT_TEMP_A_RESULT 2
`define BIT_TEMP_B_RESULT 1
`define BIT_RESERVED_LOW 0

// flag reset value and buffer-enable position in the buffer control word
`define FLAGS_RESET 9'h000
`define BIT_BUFFER_ENABLE_RESET 15

`endif

// ### design/touch_adc_pkg.sv
// types shared by the result status logic
// assumes the params header is compiled alongside
package touch_adc_pkg;

	// buffer mode as seen by the status logic
	typedef enum logic {
		MODE_DIRECT,
		MODE_BUFFER
	} bufmode_type;

	// channel order of the flag vector, index 0 first
	typedef enum logic [3:0] {
		CH_X,
		CH_Y,
		CH_P1,
		CH_P2,
		CH_BATTERY,
		CH_AUX_A,
		CH_AUX_B,
		CH_TEMP_A,
		CH_TEMP_B
	} channel_type;

endpackage : touch_adc_pkg

// ### design/result_flag_bank.sv
// bank of sticky new-result flags, one per converter channel
// assumes set and clear pulses come from logic on clk_sys
`timescale 1ns/1ns
`include "touch_adc_params.svh"

module result_flag_bank (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic [`CHANNEL_COUNT-1:0] setPulse, // fresh result stored
	input wire logic [`CHANNEL_COUNT-1:0] clearPulse, // result fully read
	input wire logic flushAll, // drop every flag
	output logic [`CHANNEL_COUNT-1:0] flags_ff // current flags
);

	// next flags: a set in the clearing cycle wins, flush beats both
	wire [`CHANNEL_COUNT-1:0] keptFlags;
	wire [`CHANNEL_COUNT-1:0] nxt_flags;

	assign keptFlags = flags_ff & ~clearPulse;
	assign nxt_flags = flushAll ? `FLAGS_RESET : (keptFlags | setPulse);

	// flag storage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= `FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

endmodule : result_flag_bank

// ### design/touch_adc_result_status.sv
// per-channel new-result flags of the touch converter status register
// assumes the converter pulses newResult when a result register is
// written, and the serial register port pulses resultReadDone once
// the last bit of a result word has been shifted out to the host;
// both come from logic on clk_sys, so no synchronisers are used
`timescale 1ns/1ns
`include "touch_adc_params.svh"

module touch_adc_result_status
	import touch_adc_pkg::*;
(
	input wire logic clk_sys, // system clock, 50 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic [`CHANNEL_COUNT-1:0] newResult, // result stored
	input wire logic [`CHANNEL_COUNT-1:0] resultReadDone, // fully read
	input wire logic bufferEnableReset, // buffer control bit
	output logic [`STATUS_WIDTH-1:0] statusWord_ff, // status word
	output logic bufferModeActive_ff, // buffer mode on
	output logic pointerHold_ff // keep buffer pointers at reset
);

	// place each channel flag at its status word position
	function automatic logic [`STATUS_WIDTH-1:0] assembleStatus(
		input logic [`CHANNEL_COUNT-1:0] flags
	);
		logic [`STATUS_WIDTH-1:0] word;
		word = `STATUS_RESET;
		word[`BIT_X_RESULT] = flags[CH_X];
		word[`BIT_Y_RESULT] = flags[CH_Y];
		word[`BIT_P1_RESULT] = flags[CH_P1];
		word[`BIT_P2_RESULT] = flags[CH_P2];
		word[`BIT_BATTERY_RESULT] = flags[CH_BATTERY];
		word[`BIT_AUX_A_RESULT] = flags[CH_AUX_A];
		word[`BIT_AUX_B_RESULT] = flags[CH_AUX_B];
		word[`BIT_TEMP_A_RESULT] = flags[CH_TEMP_A];
		word[`BIT_TEMP_B_RESULT] = flags[CH_TEMP_B];
		return word;
	endfunction : assembleStatus

	// state of the buffer mode tracker
	bufmode_type modeState_ff;
	bufmode_type nxt_modeState;

	// flags held in the bank
	logic [`CHANNEL_COUNT-1:0] flags_ff;

	// flush while buffer mode is requested: flags mean nothing then,
	// so the host sees zeros instead of stale ones
	wire flushFlags;
	wire [`STATUS_WIDTH-1:0] nxt_statusWord;

	assign flushFlags = bufferEnableReset;
	assign nxt_modeState = bufferEnableReset ? MODE_BUFFER : MODE_DIRECT;

	// reserved bits stay zero and there is no write path into the word
	assign nxt_statusWord = assembleStatus(flags_ff);

	// set on stored result, clear on completed read, set wins a tie
	result_flag_bank flagBank (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.setPulse(newResult),
		.clearPulse(resultReadDone),
		.flushAll(flushFlags),
		.flags_ff(flags_ff)
	);

	// buffer mode tracker
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			modeState_ff <= MODE_DIRECT;
		end else begin
			modeState_ff <= nxt_modeState;
		end
	end

	// output registers; a one-cycle lag on the word keeps outputs on flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			statusWord_ff <= `STATUS_RESET;
			bufferModeActive_ff <= 1'b0;
			pointerHold_ff <= 1'b1;
		end else begin
			statusWord_ff <= nxt_statusWord;
			bufferModeActive_ff <= (modeState_ff == MODE_BUFFER);
			pointerHold_ff <= (modeState_ff == MODE_DIRECT);
		end
	end

	// ---- checks ----
	// a fresh result outside buffer mode shows two cycles later
	sequence s_set(int ch);
		newResult[ch] && !bufferEnableReset;
	endsequence

	// a completed read with no new result in the same cycle
	sequence s_clear(int ch);
		resultReadDone[ch] && !newResult[ch];
	endsequence

	// flag follows set, and drops after a clean read
	property p_channel(int ch, int pos);
		@(posedge clk_sys) disable iff (!rst_n)
		(s_set(ch) |-> ##2 statusWord_ff[pos]) and
		(s_clear(ch) |-> ##2 !statusWord_ff[pos]);
	endproperty

	// a flag that is up and not read stays up
	property p_hold(int ch, int pos);
		@(posedge clk_sys) disable iff (!rst_n)
		(flags_ff[ch] && !resultReadDone[ch] && !bufferEnableReset)
			|-> ##2 statusWord_ff[pos];
	endproperty

	a_x_flag_life:
		assert property (p_channel(CH_X, `BIT_X_RESULT))
		else $error("x result flag wrong");

	a_x_flag_hold:
		assert property (p_hold(CH_X, `BIT_X_RESULT))
		else $error("x result flag lost before read");

	a_y_flag_life:
		assert property (p_channel(CH_Y, `BIT_Y_RESULT))
		else $error("y result flag wrong");

	a_p1_flag_life:
		assert property (p_channel(CH_P1, `BIT_P1_RESULT))
		else $error("pressure1 result flag wrong");

	a_p2_flag_life:
		assert property (p_channel(CH_P2, `BIT_P2_RESULT))
		else $error("pressure2 result flag wrong");

	a_battery_flag_life:
		assert property (p_channel(CH_BATTERY, `BIT_BATTERY_RESULT))
		else $error("battery result flag wrong");

	a_aux_a_life:
		assert property (p_channel(CH_AUX_A, `BIT_AUX_A_RESULT))
		else $error("aux a result flag wrong");

	a_aux_b_life:
		assert property (p_channel(CH_AUX_B, `BIT_AUX_B_RESULT))
		else $error("aux b result flag wrong");

	a_temp_a_life:
		assert property (p_channel(CH_TEMP_A, `BIT_TEMP_A_RESULT))
		else $error("temp a result flag wrong");

	a_temp_b_life:
		assert property (p_channel(CH_TEMP_B, `BIT_TEMP_B_RESULT))
		else $error("temp b result flag wrong");

	a_temp_b_hold:
		assert property (p_hold(CH_TEMP_B, `BIT_TEMP_B_RESULT))
		else $error("temp b result flag lost before read");

	// a set that meets its own clear still lands
	a_set_beats_clear:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			(newResult[CH_BATTERY] && resultReadDone[CH_BATTERY]
				&& !bufferEnableReset)
			|=> flags_ff[CH_BATTERY])
		else $error("set lost against clear");

	// buffer mode empties the word and reports itself two edges on
	a_buffer_flush:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			bufferEnableReset |-> ##2 (statusWord_ff == `STATUS_RESET))
		else $error("flags survive buffer mode");

	a_buffer_mode_out:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			$rose(bufferEnableReset) |-> ##2
				(bufferModeActive_ff && !pointerHold_ff))
		else $error("buffer mode not reported");

	a_pointer_hold:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			!bufferEnableReset [*2] |-> ##1 pointerHold_ff)
		else $error("pointers not held while buffer off");

	a_reserved_zero:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			!statusWord_ff[`BIT_RESERVED_LOW]
			&& !statusWord_ff[`BIT_RESERVED_HIGH]
			&& (statusWord_ff[`STATUS_WIDTH-1:`BIT_X_RESULT+1] == 5'h00))
		else $error("reserved status bit set");

	a_word_matches:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			##1 statusWord_ff == assembleStatus($past(flags_ff)))
		else $error("status word out of step with flags");

	// a fresh result met by buffer mode is dropped, not kept
	a_flush_drops_set:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			(bufferEnableReset && (newResult != `FLAGS_RESET))
			|=> (flags_ff == `FLAGS_RESET))
		else $error("result kept during buffer mode");

	a_y_flag_hold:
		assert property (p_hold(CH_Y, `BIT_Y_RESULT))
		else $error("y result flag lost before read");

	// leaving buffer mode holds the pointers again two edges on
	a_buffer_mode_exit:
		assert property (@(posedge clk_sys) disable iff (!rst_n)
			$fell(bufferEnableReset) |-> ##2
				(!bufferModeActive_ff && pointerHold_ff))
		else $error("buffer mode exit not reported");

endmodule : touch_adc_result_status

// ### testbench/result_source_model.sv
// partner model: converter result writes and serial read completion
// assumes the bench calls its task from one process, just after an edge
`timescale 1ns/1ns
`include "touch_adc_params.svh"

module result_source_model (
	input wire logic clk_sys, // system clock
	output logic [`CHANNEL_COUNT-1:0] newResult, // result stored
	output logic [`CHANNEL_COUNT-1:0] resultReadDone // result fully read
);
	// quiet until the first request
	initial begin
		newResult = 9'h000;
		resultReadDone = 9'h000;
	end

	// one-cycle pulses: launched at an edge, taken at the next one
	// a read-done pulse stands for the whole result word shifted out
	task automatic pulse(input logic [`CHANNEL_COUNT-1:0] s,
		input logic [`CHANNEL_COUNT-1:0] c);
		@(posedge clk_sys);
		newResult <= s;
		resultReadDone <= c;
		@(posedge clk_sys);
		newResult <= 9'h000;
		resultReadDone <= 9'h000;
	endtask : pulse
endmodule : result_source_model

// ### testbench/touch_adc_result_status_tb.sv
// self-checking bench for the result status flags
// assumes the partner model drives the pulse inputs
`timescale 1ns/1ns
`include "touch_adc_params.svh"

module touch_adc_result_status_tb;
	import touch_adc_pkg::*;
	logic clk_sys; // 50 MHz clock
	logic rst_n; // reset, active low
	logic bufferEnableReset; // buffer mode request
	logic [`CHANNEL_COUNT-1:0] newResult; // from the model
	logic [`CHANNEL_COUNT-1:0] resultReadDone; // from the model
	logic [15:0] statusWord; // observed word
	logic bufferMode; // observed mode
	logic pointerHold; // observed pointer hold
	int fail_count; // mismatches
	int checked; // comparisons made
	int bitPos [9] = '{10, 9, 8, 7, 6, 4, 3, 2, 1}; // channel to bit

	result_source_model result_source_model_i (.clk_sys(clk_sys),
		.newResult(newResult), .resultReadDone(resultReadDone));
	touch_adc_result_status touch_adc_result_status_i (.clk_sys(clk_sys),
		.rst_n(rst_n), .newResult(newResult),
		.resultReadDone(resultReadDone),
		.bufferEnableReset(bufferEnableReset), .statusWord_ff(statusWord),
		.bufferModeActive_ff(bufferMode), .pointerHold_ff(pointerHold));

	// free-running clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// one compare for every 16-bit or narrower result
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// the word lags the pulse edge by one more edge
	task automatic settle();
		@(posedge clk_sys);
		#1;
	endtask : settle

	task automatic give_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict

	// a hang is cut well past the fewer than a hundred cycles the tests take
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end

	// main sequence
	initial begin
		rst_n = 1'b0;
		bufferEnableReset = 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		settle();
		chk("reset word", 16'h0000, statusWord);
		chk("reset hold", 16'h0001, {15'h0000, pointerHold});
		chk("reset mode", 16'h0000, {15'h0000, bufferMode});
		// each channel alone: set lands on its own bit, read clears it
		for (int i = 0; i < 9; i++) begin
			result_source_model_i.pulse(9'h001 << i, 9'h000);
			settle();
			chk("set", 16'h0001 << bitPos[i], statusWord);
			result_source_model_i.pulse(9'h000, 9'h001 << i);
			settle();
			chk("clear", 16'h0000, statusWord);
		end
		// all at once: reserved bits and upper bits stay low
		result_source_model_i.pulse(9'h1ff, 9'h000);
		settle();
		chk("all set", 16'h07de, statusWord);
		// a new result beats a read finishing in the same cycle
		result_source_model_i.pulse(9'h011, 9'h011);
		settle();
		chk("set wins", 16'h07de, statusWord);
		// buffer mode flushes flags and drops fresh sets
		@(posedge clk_sys);
		bufferEnableReset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("buf word", 16'h0000, statusWord);
		chk("buf mode", 16'h0001, {15'h0000, bufferMode});
		chk("buf hold", 16'h0000, {15'h0000, pointerHold});
		result_source_model_i.pulse(9'h1ff, 9'h000);
		settle();
		chk("buf drop", 16'h0000, statusWord);
		@(posedge clk_sys);
		bufferEnableReset <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("off mode", 16'h0000, {15'h0000, bufferMode});
		chk("off hold", 16'h0001, {15'h0000, pointerHold});
		// flags are trusted again only after a fresh result
		result_source_model_i.pulse(9'h002, 9'h000);
		settle();
		chk("fresh", 16'h0200, statusWord);
		// a second reset in mid-run empties the word
		@(posedge clk_sys);
		rst_n <= 1'b0;
		settle();
		chk("rerst", 16'h0000, statusWord);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		settle();
		chk("rerst word", 16'h0000, statusWord);
		chk("rerst hold", 16'h0001, {15'h0000, pointerHold});
		chk("rerst mode", 16'h0000, {15'h0000, bufferMode});
		// a pulse launched at the second edge after the release is taken at the third
		result_source_model_i.pulse(9'h100, 9'h000);
		settle();
		chk("rerst set", 16'h0002, statusWord);
		give_verdict();
	end
endmodule : touch_adc_result_status_tb
